// File: rtl/rcv_exception_unit.sv
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "rcv_defines.svh"

module rcv_exception_unit (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [2:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  input wire logic rst_pin_in,
  output logic rst_pin_out,
  output logic rst_pin_oe,
  output logic core_reset,
  input wire logic watchdog_timeout,
  input wire logic undervoltage_trip,
  input wire logic monitor_entry_req,
  input wire logic opfetch_strobe,
  input wire logic [15:0] opfetch_addr,
  input wire logic opfetch_addr_mapped,
  input wire logic opcode_known,
  input wire logic opcode_is_stop,
  input wire logic instr_done,
  input wire logic swi_exec,
  input wire logic rti_exec,
  input wire logic imask,
  input wire logic [15:0] cpu_pc,
  input wire logic [7:0] cpu_x,
  input wire logic [7:0] cpu_a,
  input wire logic [7:0] cpu_ccr,
  output logic force_swi,
  input wire logic [33:0] pending_source_flag,
  input wire logic [33:0] source_enable,
  output logic entry_busy,
  output logic stack_push,
  output logic [7:0] stack_data,
  output logic unstack_pop,
  output logic set_imask,
  output logic pc_load,
  output logic [15:0] vector_addr
);

  localparam logic [169:0] LEVEL_MAP = `RCV_LEVEL_MAP;

  rcv_pkg::rcv_rst_state_t rst_state;
  rcv_pkg::rcv_ent_state_t ent_state;
  logic [5:0] rst_cnt;
  logic pin_s1;
  logic pin_s2;
  logic pin_s3;
  logic pin_level;
  logic pin_low;
  logic [7:0] reset_cause_status;
  logic [7:0] next_status;
  logic [7:0] set_vec;
  logic status_rd;
  logic [1:0] cfg;
  logic [15:0] brk_addr;
  logic bad_op;
  logic bad_addr;
  logic int_reset_evt;
  logic sample_end;
  logic [`RCV_NUM_LEVELS:1] level_req;
  logic [4:0] win_level;
  logic any_req;
  logic take_swi;
  logic take_hw;
  logic [2:0] ent_cnt;
  logic [39:0] snap;

  // Reset pin synchroniser; a new level counts only once stages two and three agree.
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      pin_s1 <= 1'b1;
      pin_s2 <= 1'b1;
      pin_s3 <= 1'b1;
      pin_level <= 1'b1;
    end
    else
    begin
      pin_s1 <= rst_pin_in;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      if (pin_s2 == pin_s3)
      begin
        pin_level <= pin_s3;
      end
    end
  end

  assign pin_low = !pin_level;

  // Only opcode fetches are checked, so operand reads of holes stay harmless.
  assign bad_op = opfetch_strobe && !core_reset &&
                  (!opcode_known || (opcode_is_stop && !cfg[`RCV_CFG_STOP_EN])); // RQ1 RQ2
  assign bad_addr = opfetch_strobe && !core_reset && !opfetch_addr_mapped; // RQ3 RQ4
  assign int_reset_evt = bad_op || bad_addr || watchdog_timeout || undervoltage_trip ||
                         monitor_entry_req;
  assign sample_end = (rst_state == rcv_pkg::RS_WAIT) &&
                      (rst_cnt == `RCV_SAMPLE_CYC - 6'h01);

  // Power-up starts a full internal sequence so attached devices see the pin pulled low.
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      rst_state <= rcv_pkg::RS_DRIVE;
      rst_cnt <= 6'h00;
    end
    else
    begin
      unique case (rst_state)
        rcv_pkg::RS_RUN:
        begin
          rst_cnt <= 6'h00;
          if (int_reset_evt)
          begin
            rst_state <= rcv_pkg::RS_DRIVE;
          end
          else if (pin_low)
          begin
            rst_state <= rcv_pkg::RS_EXT;
          end
        end
        rcv_pkg::RS_DRIVE:
        begin
          if (rst_cnt == `RCV_PIN_LOW_CYC - 6'h01)
          begin
            rst_state <= rcv_pkg::RS_WAIT;
            rst_cnt <= 6'h00;
          end
          else
          begin
            rst_cnt <= rst_cnt + 6'h01;
          end
        end
        rcv_pkg::RS_WAIT:
        begin
          rst_cnt <= rst_cnt + 6'h01;
          if (sample_end)
          begin
            rst_state <= pin_low ? rcv_pkg::RS_EXT : rcv_pkg::RS_RUN; // RQ7
            rst_cnt <= 6'h00;
          end
        end
        rcv_pkg::RS_EXT:
        begin
          if (!pin_low)
          begin
            rst_state <= rcv_pkg::RS_RUN;
          end
        end
      endcase
    end
  end

  assign core_reset = (rst_state != rcv_pkg::RS_RUN);
  assign rst_pin_oe = (rst_state == rcv_pkg::RS_DRIVE);
  assign rst_pin_out = 1'b0;

  // Cause flags only ever set here; clearing is left to the status read.
  always_comb
  begin
    set_vec = 8'h00;
    if (rst_state == rcv_pkg::RS_RUN)
    begin
      set_vec[`RCV_ST_WATCHDOG] = watchdog_timeout; // RQ10
      set_vec[`RCV_ST_BAD_OPCODE] = bad_op; // RQ1 RQ2
      set_vec[`RCV_ST_BAD_ADDRESS] = bad_addr; // RQ3
      set_vec[`RCV_ST_MONITOR] = monitor_entry_req; // RQ10
      set_vec[`RCV_ST_UNDERVOLTAGE] = undervoltage_trip; // RQ10
      set_vec[`RCV_ST_PIN] = pin_low && !int_reset_evt; // RQ9
    end
    if (sample_end && pin_low)
    begin
      set_vec[`RCV_ST_PIN] = 1'b1; // RQ7
    end
  end

  assign status_rd = bus_rd && (bus_addr == `RCV_ADDR_STATUS);
  // A set in the same cycle as the read survives the clear.
  assign next_status = (status_rd ? 8'h00 : reset_cause_status) | set_vec; // RQ5 RQ8 RQ24

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      reset_cause_status <= `RCV_STATUS_RESET; // RQ6 RQ9
    end
    else
    begin
      reset_cause_status <= next_status;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      cfg <= `RCV_CFG_RESET;
      brk_addr <= `RCV_BRK_RESET;
    end
    else if (bus_wr)
    begin
      unique case (bus_addr)
        `RCV_ADDR_CONFIG: cfg <= bus_wdata[1:0];
        `RCV_ADDR_BRK_HI: brk_addr[15:8] <= bus_wdata;
        `RCV_ADDR_BRK_LO: brk_addr[7:0] <= bus_wdata;
        default: cfg <= cfg;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      bus_rdata <= 8'h00;
    end
    else if (bus_rd)
    begin
      unique case (bus_addr)
        `RCV_ADDR_STATUS: bus_rdata <= reset_cause_status;
        `RCV_ADDR_CONFIG: bus_rdata <= {6'h00, cfg};
        `RCV_ADDR_BRK_HI: bus_rdata <= brk_addr[15:8];
        `RCV_ADDR_BRK_LO: bus_rdata <= brk_addr[7:0];
        default: bus_rdata <= 8'h00;
      endcase
    end
  end

  assign force_swi = cfg[`RCV_CFG_BRK_EN] && opfetch_strobe && !core_reset &&
                     (opfetch_addr == brk_addr); // RQ19

  // Shared vectors collapse to one request per level.
  always_comb
  begin
    level_req = '0;
    for (int i = 0; i < `RCV_NUM_FLAGS; i++)
    begin
      if (pending_source_flag[i] && source_enable[i])
      begin
        level_req[LEVEL_MAP[i*5 +: 5]] = 1'b1; // RQ23
      end
    end
  end

  // Scanning downward lets the lowest number overwrite, which is the highest priority.
  always_comb
  begin
    win_level = 5'h00;
    any_req = 1'b0;
    for (int l = `RCV_NUM_LEVELS; l >= 1; l--)
    begin
      if (level_req[l])
      begin
        win_level = 5'(l); // RQ14 RQ21
        any_req = 1'b1;
      end
    end
  end

  // The trap is the completing instruction itself, so it needs no mask check.
  assign take_swi = swi_exec && (ent_state == rcv_pkg::ENT_IDLE) && !core_reset; // RQ17
  assign take_hw = instr_done && !swi_exec && !imask && any_req &&
                   (ent_state == rcv_pkg::ENT_IDLE) && !core_reset; // RQ11 RQ14 RQ22

  always_ff @(posedge mclk)
  begin
    if (!rstn || core_reset)
    begin
      ent_state <= rcv_pkg::ENT_IDLE;
      ent_cnt <= 3'h0;
    end
    else
    begin
      unique case (ent_state)
        rcv_pkg::ENT_IDLE:
        begin
          ent_cnt <= 3'h0;
          if (take_swi || take_hw)
          begin
            ent_state <= rcv_pkg::ENT_PUSH;
          end
          else if (rti_exec)
          begin
            // Once popped, the next completion re-arbitrates before program code runs.
            ent_state <= rcv_pkg::ENT_POP; // RQ12 RQ15
          end
        end
        rcv_pkg::ENT_PUSH:
        begin
          ent_cnt <= ent_cnt + 3'h1;
          if (ent_cnt == `RCV_STACK_BYTES - 3'h1)
          begin
            ent_state <= rcv_pkg::ENT_MASK;
          end
        end
        rcv_pkg::ENT_MASK:
        begin
          ent_state <= rcv_pkg::ENT_VECTOR;
        end
        rcv_pkg::ENT_VECTOR:
        begin
          ent_state <= rcv_pkg::ENT_IDLE;
        end
        rcv_pkg::ENT_POP:
        begin
          ent_cnt <= ent_cnt + 3'h1;
          if (ent_cnt == `RCV_STACK_BYTES - 3'h1)
          begin
            ent_state <= rcv_pkg::ENT_IDLE;
          end
        end
        default: ent_state <= rcv_pkg::ENT_IDLE;
      endcase
    end
  end

  // Snapshot of the stacked bytes, low byte pushed first; the high index byte is absent.
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      snap <= 40'h0;
    end
    else if (take_swi)
    begin
      snap <= {cpu_ccr, cpu_a, cpu_x, cpu_pc}; // RQ16 RQ18
    end
    else if (take_hw)
    begin
      snap <= {cpu_ccr, cpu_a, cpu_x, cpu_pc - 16'h0001}; // RQ16 RQ18
    end
    else if (ent_state == rcv_pkg::ENT_PUSH)
    begin
      snap <= {8'h00, snap[39:8]};
    end
  end

  // Vector latched at acceptance and held through entry; only a core reset can pre-empt it.
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      vector_addr <= `RCV_VEC_RESET;
    end
    else if (core_reset)
    begin
      vector_addr <= `RCV_VEC_RESET; // RQ20
    end
    else if (take_swi)
    begin
      vector_addr <= `RCV_VEC_SWI; // RQ13 RQ20
    end
    else if (take_hw)
    begin
      vector_addr <= `RCV_VEC_SWI - {10'h000, win_level, 1'b0}; // RQ13 RQ20
    end
  end

  assign stack_data = snap[7:0];
  assign stack_push = (ent_state == rcv_pkg::ENT_PUSH); // RQ12
  assign set_imask = (ent_state == rcv_pkg::ENT_MASK); // RQ12
  assign pc_load = (ent_state == rcv_pkg::ENT_VECTOR); // RQ12
  assign unstack_pop = (ent_state == rcv_pkg::ENT_POP); // RQ12
  assign entry_busy = (ent_state != rcv_pkg::ENT_IDLE);

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  chk_opcode_flag: assert property (bad_op && rst_state == rcv_pkg::RS_RUN |=> // RQ1
    reset_cause_status[`RCV_ST_BAD_OPCODE] && rst_state == rcv_pkg::RS_DRIVE)
    else $error("illegal opcode did not reset and flag");
  chk_stop_illegal: assert property (opfetch_strobe && opcode_known && opcode_is_stop && // RQ2
    !cfg[`RCV_CFG_STOP_EN] && rst_state == rcv_pkg::RS_RUN |=> rst_pin_oe)
    else $error("disabled stop did not reset");
  chk_address_flag: assert property (bad_addr && rst_state == rcv_pkg::RS_RUN |=> // RQ3
    reset_cause_status[`RCV_ST_BAD_ADDRESS])
    else $error("unmapped opcode fetch not flagged");
  chk_data_fetch_safe: assert property (rst_state == rcv_pkg::RS_RUN && // RQ4
    !int_reset_evt && !pin_low |=> rst_state == rcv_pkg::RS_RUN)
    else $error("reset without an opcode-side cause");
  chk_read_clears: assert property (status_rd && set_vec == 8'h00 |=> // RQ5
    reset_cause_status == 8'h00)
    else $error("status read did not clear flags");
  chk_pin_sample: assert property ($fell(rst_pin_oe) |-> // RQ7
    (rst_state == rcv_pkg::RS_WAIT)[*8] ##24 (rst_state == rcv_pkg::RS_WAIT) ##1
    (rst_state != rcv_pkg::RS_WAIT))
    else $error("pin not sampled 32 cycles after release");
  chk_flags_keep: assert property (!status_rd |=> // RQ8
    (reset_cause_status & $past(reset_cause_status)) == $past(reset_cause_status))
    else $error("flag lost without a read");
  chk_set_wins: assert property (status_rd && set_vec != 8'h00 |=> // RQ24
    (reset_cause_status & $past(set_vec)) == $past(set_vec))
    else $error("read clear beat a new reset flag");
  chk_entry_cause: assert property ($rose(entry_busy) |-> // RQ11
    $past(instr_done || swi_exec || rti_exec))
    else $error("entry started mid-instruction");
  chk_entry_seq: assert property ($rose(stack_push) |-> // RQ12
    stack_push[*5] ##1 set_imask ##1 pc_load ##1 !entry_busy)
    else $error("entry sequence wrong");
  chk_vector_held: assert property (entry_busy && $past(entry_busy) && !core_reset |-> // RQ13
    $stable(vector_addr))
    else $error("latched vector changed during entry");
  chk_mask_blocks: assert property (instr_done && imask && !swi_exec && !rti_exec && // RQ22
    ent_state == rcv_pkg::ENT_IDLE |=> !entry_busy)
    else $error("masked request entered");
  chk_swi_stack_pc: assert property (take_swi |=> snap[15:0] == $past(cpu_pc)) // RQ18
    else $error("trap stacked wrong pc");
  chk_hw_stack_pc: assert property (take_hw |=> // RQ18
    snap[15:0] == $past(cpu_pc) - 16'h0001)
    else $error("interrupt did not stack pc minus one");

  cov_bad_opcode: cover property (bad_op && rst_state == rcv_pkg::RS_RUN);
  cov_hw_entry: cover property (take_hw ##1 stack_push);
  cov_swi_entry: cover property (take_swi ##1 stack_push);
  cov_pin_flag: cover property (sample_end && pin_low);

endmodule : rcv_exception_unit
`default_nettype wire

// File: rtl/rcv_defines.svh
// Functional notes
// RQ1: An opcode outside the instruction set raises internal reset and sets bad_opcode_flag.
// RQ2: With stop-enable option at 0, the stop instruction counts as an illegal opcode.
// RQ3: An opcode fetch from an unmapped address resets and sets bad_address_flag.
// RQ4: Data fetches from unmapped addresses never reset; only opcode fetches are checked.
// RQ5: The status register is read-only and any read clears every flag.
// RQ6: After power-up the status register holds only the power-on flag set.
// RQ7: The reset pin is sampled 32 cycles after release; low then sets the pin flag.
// RQ8: Flags accumulate across resets until a read clears them.
// RQ9: Power-on and pin flags report their reset since the last read.
// RQ10: Watchdog, opcode, address, monitor and undervoltage flags report their reset cause.
// RQ11: Interrupt entry starts only after the current instruction completes.
// RQ12: Entry stacks registers, sets the mask, loads the vector; return restores the stack.
// RQ13: A latched interrupt cannot be pre-empted by any other request.
// RQ14: With the mask clear, each instruction end services the highest pending request.
// RQ15: A request pending at return is serviced before the next program instruction.
// RQ16: Entry never stacks the high index byte.
// RQ17: The software trap is taken regardless of the interrupt mask.
// RQ18: A trap stacks the program counter; a hardware interrupt stacks it minus one.
// RQ19: A matching break point forces the CPU to execute the software trap.
// RQ20: Each level has a fixed vector pair, from FFFE reset down to FFD4 at 20.
// RQ21: A lower level number is a higher priority, level zero the highest.
// RQ22: The mask bit blocks every source except the software trap.
// RQ23: Each flag is gated by its enable; shared vectors request on any enabled flag.
// RQ24: A reset flag set in the cycle of a status read wins over the clear.
`ifndef RCV_DEFINES_SVH
`define RCV_DEFINES_SVH

`define RCV_ADDR_STATUS 3'h0
`define RCV_ADDR_CONFIG 3'h1
`define RCV_ADDR_BRK_HI 3'h2
`define RCV_ADDR_BRK_LO 3'h3

`define RCV_ST_POWER_ON 7
`define RCV_ST_PIN 6
`define RCV_ST_WATCHDOG 5
`define RCV_ST_BAD_OPCODE 4
`define RCV_ST_BAD_ADDRESS 3
`define RCV_ST_MONITOR 2
`define RCV_ST_UNDERVOLTAGE 1
`define RCV_STATUS_RESET 8'h80

`define RCV_CFG_STOP_EN 0
`define RCV_CFG_BRK_EN 1
`define RCV_CFG_RESET 2'h0
`define RCV_BRK_RESET 16'h0000

`define RCV_PIN_LOW_CYC 6'h20
`define RCV_SAMPLE_CYC 6'h20

`define RCV_STACK_BYTES 3'h5
`define RCV_VEC_RESET 16'hfffe
`define RCV_VEC_SWI 16'hfffc
`define RCV_NUM_FLAGS 34
`define RCV_NUM_LEVELS 20
// Level of each flag input, flag 33 first.
`define RCV_LEVEL_MAP {5'h14, 5'h14, 5'h14, 5'h13, 5'h12, 5'h12, 5'h12, 5'h12, 5'h12, \
  5'h12, 5'h11, 5'h10, 5'h0f, 5'h0e, 5'h0d, 5'h0d, 5'h0c, 5'h0c, 5'h0b, 5'h0b, 5'h0b, \
  5'h0b, 5'h0a, 5'h09, 5'h09, 5'h09, 5'h08, 5'h07, 5'h06, 5'h05, 5'h04, 5'h03, 5'h02, 5'h01}

`endif

// File: rtl/rcv_pkg.sv
package rcv_pkg;
  typedef enum logic [1:0] {RS_RUN, RS_DRIVE, RS_WAIT, RS_EXT} rcv_rst_state_t;
  typedef enum logic [2:0] {ENT_IDLE, ENT_PUSH, ENT_MASK, ENT_VECTOR, ENT_POP} rcv_ent_state_t;
endpackage : rcv_pkg

// File: tb/rcv_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
// CPU side of the exception unit: keeps the I bit and records the pushed bytes.
module rcv_cpu_model (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic stack_push,
  input wire logic [7:0] stack_data,
  input wire logic set_imask,
  input wire logic unstack_pop,
  output logic imask,
  output logic [39:0] stacked
);
  logic [2:0] pops;
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      imask <= 1'b0;
      pops <= 3'h0;
    end
    else if (set_imask)
      imask <= 1'b1;
    else if (unstack_pop)
    begin
      // The restored status byte had the I bit clear, so the last pop unmasks.
      pops <= (pops == 3'h4) ? 3'h0 : pops + 3'h1;
      if (pops == 3'h4)
        imask <= 1'b0;
    end
  end
  // The first byte pushed ends up in the low byte after five pushes.
  always_ff @(posedge mclk)
    if (stack_push)
      stacked <= {stack_data, stacked[39:8]};
endmodule : rcv_cpu_model
`default_nettype wire

// File: tb/reset_cause_and_interrupt_vectoring_tb.sv
`timescale 1ns/100ps
`default_nettype none
module reset_cause_and_interrupt_vectoring_tb;
  localparam int WD = 0, UV = 1, MON = 2, OPF = 3, IDN = 4, TRAP = 5, RET = 6;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] bus_addr = 3'h0;
  logic [7:0] bus_wdata = 8'h00;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [7:0] bus_rdata;
  logic [6:0] ev = 7'h00;
  logic ext_low = 1'b0;
  logic rst_pin_in, rst_pin_out, rst_pin_oe, core_reset, force_swi, entry_busy;
  logic stack_push, unstack_pop, set_imask, pc_load, imask;
  logic [7:0] stack_data;
  logic [15:0] vector_addr;
  logic [39:0] stacked;
  logic [15:0] opfetch_addr = 16'h0100;
  logic mapped = 1'b1;
  logic known = 1'b1;
  logic is_stop = 1'b0;
  logic [33:0] pend = 34'h0;
  logic [33:0] en = 34'h0;
  logic [15:0] pc = 16'h2345;
  int fails = 0;
  int checks_done = 0;
  int k, n;
  // The pin has a pull-up; only the device or the outside world pulls it low.
  assign rst_pin_in = rst_pin_oe ? rst_pin_out : !ext_low;
  initial forever #5 mclk = ~mclk;

  rcv_exception_unit DUT (.mclk(mclk), .rstn(rstn), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
    .core_reset(core_reset), .watchdog_timeout(ev[WD]), .undervoltage_trip(ev[UV]),
    .monitor_entry_req(ev[MON]), .opfetch_strobe(ev[OPF]), .opfetch_addr(opfetch_addr),
    .opfetch_addr_mapped(mapped), .opcode_known(known), .opcode_is_stop(is_stop),
    .instr_done(ev[IDN]), .swi_exec(ev[TRAP]), .rti_exec(ev[RET]), .imask(imask),
    .cpu_pc(pc), .cpu_x(8'h5a), .cpu_a(8'h3c), .cpu_ccr(8'h61), .force_swi(force_swi),
    .pending_source_flag(pend), .source_enable(en), .entry_busy(entry_busy),
    .stack_push(stack_push), .stack_data(stack_data), .unstack_pop(unstack_pop),
    .set_imask(set_imask), .pc_load(pc_load), .vector_addr(vector_addr));

  rcv_cpu_model cpu (.mclk(mclk), .rstn(rstn), .stack_push(stack_push),
    .stack_data(stack_data), .set_imask(set_imask), .unstack_pop(unstack_pop),
    .imask(imask), .stacked(stacked));

  task chk(input logic [39:0] got, input logic [39:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task end_of_test;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  task wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge mclk);
    bus_addr <= a;
    bus_wdata <= v;
    bus_wr <= 1'b1;
    @(posedge mclk);
    bus_wr <= 1'b0;
  endtask : wr

  task rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge mclk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge mclk);
    bus_rd <= 1'b0;
    #1;
    chk(bus_rdata, exp);
  endtask : rd

  task pulse(input int i);
    @(posedge mclk);
    ev[i] <= 1'b1;
    @(posedge mclk);
    ev <= 7'h00;
    #1;
  endtask : pulse

  // Counts the cycles the device pulls the pin and lets the outside go at step rel.
  task wait_reset(input bit cnt, input int rel);
    n = 0;
    for (k = 0; k < 300 && core_reset === 1'b1; k++)
    begin
      if (k == rel)
        ext_low <= 1'b0;
      if (rst_pin_oe === 1'b1)
        n++;
      @(posedge mclk);
      #1;
    end
    if (cnt)
      chk(n, 32);
    chk(core_reset, 1'b0);
  endtask : wait_reset

  task entry(input int i, input bit poke, input logic [15:0] vec, input logic [15:0] spc);
    pulse(i);
    if (poke)
    begin
      en[0] <= 1'b1;
      pulse(IDN);
    end
    for (k = 0; k < 20 && pc_load !== 1'b1; k++)
    begin
      @(posedge mclk);
      #1;
    end
    chk(vector_addr, vec);
    chk(stacked, {8'h61, 8'h3c, 8'h5a, spc});
    @(posedge mclk);
    #1;
    chk(entry_busy, 1'b0);
  endtask : entry

  initial
  begin
    // Generous limit; the full sequence needs under a thousand cycles.
    #200000;
    fails++;
    end_of_test;
  end

  initial
  begin
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    #1;
    chk(vector_addr, 16'hfffe);
    wait_reset(0, 0);
    rd(3'h0, 8'h80);
    rd(3'h0, 8'h00);
    wr(3'h0, 8'hff);
    rd(3'h0, 8'h00);
    rd(3'h5, 8'h00);
    rd(3'h1, 8'h00);
    known <= 1'b0;
    pulse(OPF);
    known <= 1'b1;
    wait_reset(1, 0);
    rd(3'h0, 8'h10);
    is_stop <= 1'b1;
    pulse(OPF);
    wait_reset(1, 0);
    rd(3'h0, 8'h10);
    wr(3'h1, 8'h01);
    pulse(OPF);
    repeat (3) @(posedge mclk);
    chk(core_reset, 1'b0);
    is_stop <= 1'b0;
    mapped <= 1'b0;
    repeat (4) @(posedge mclk);
    chk(core_reset, 1'b0);
    pulse(OPF);
    mapped <= 1'b1;
    wait_reset(1, 0);
    rd(3'h0, 8'h08);
    pulse(WD);
    wait_reset(1, 0);
    pulse(UV);
    wait_reset(1, 0);
    pulse(MON);
    wait_reset(1, 0);
    rd(3'h0, 8'h26);
    pulse(WD);
    ext_low <= 1'b1;
    wait_reset(1, 80);
    rd(3'h0, 8'h60);
    ext_low <= 1'b1;
    repeat (8) @(posedge mclk);
    #1;
    wait_reset(0, 20);
    rd(3'h0, 8'h40);
    @(posedge mclk);
    bus_addr <= 3'h0;
    bus_rd <= 1'b1;
    ev[WD] <= 1'b1;
    @(posedge mclk);
    bus_rd <= 1'b0;
    ev <= 7'h00;
    #1;
    wait_reset(1, 0);
    rd(3'h0, 8'h20);
    wr(3'h2, 8'h12);
    wr(3'h3, 8'h34);
    wr(3'h1, 8'h03);
    opfetch_addr <= 16'h1234;
    @(posedge mclk);
    ev[OPF] <= 1'b1;
    #1;
    chk(force_swi, 1'b1);
    @(posedge mclk);
    ev <= 7'h00;
    opfetch_addr <= 16'h0100;
    pend <= 34'h080000021;
    en <= 34'h080000020;
    repeat (3) @(posedge mclk);
    #1;
    chk(entry_busy, 1'b0);
    entry(IDN, 1, 16'hfff0, pc - 16'h0001);
    pulse(IDN);
    repeat (3) @(posedge mclk);
    #1;
    chk(entry_busy, 1'b0);
    entry(TRAP, 0, 16'hfffc, pc);
    pulse(RET);
    n = 0;
    for (k = 0; k < 10; k++)
    begin
      if (unstack_pop === 1'b1)
        n++;
      @(posedge mclk);
      #1;
    end
    chk(n, 5);
    entry(IDN, 0, 16'hfffa, pc - 16'h0001);
    end_of_test;
  end
endmodule : reset_cause_and_interrupt_vectoring_tb
`default_nettype wire
